// ### common/tpf_pkg.sv
// Package of constants and types for the tilt packet framer.
package tpf_pkg;
   localparam int          TPF_PKT_LEN       = 10;
   localparam logic [7:0]  TPF_SYNC_BYTE     = 8'hFE;
   localparam logic [3:0]  TPF_POS_SYNC1     = 4'h0;
   localparam logic [3:0]  TPF_POS_SYNC2     = 4'h1;
   localparam logic [3:0]  TPF_POS_AXIS_A_HI = 4'h2;
   localparam logic [3:0]  TPF_POS_AXIS_B_HI = 4'h4;
   localparam logic [3:0]  TPF_POS_RSV_HI    = 4'h6;
   localparam logic [3:0]  TPF_POS_CSUM_HI   = 4'h8;
   localparam logic [3:0]  TPF_POS_LAST      = 4'h9;
   localparam int          TPF_ANGLE_SCALE   = 10;
   localparam int          TPF_ANGLE_W       = 16;
   localparam logic [15:0] TPF_ANGLE_MAX     = 16'h0E10;
   localparam int          TPF_CLK_HZ        = 20000000;
   localparam int          TPF_BAUD_HIGH     = 115200;
   localparam int          TPF_BAUD_LOW      = 57600;
   localparam int          TPF_DIV_HIGH      = TPF_CLK_HZ / TPF_BAUD_HIGH;
   localparam int          TPF_DIV_LOW       = TPF_CLK_HZ / TPF_BAUD_LOW;
   localparam int          TPF_DIV_W         = 10;
   localparam int          TPF_FIFO_DEPTH    = 32;
   localparam int          TPF_UART_BITS     = 10;
   localparam logic        TPF_MODE_TWO_AXIS = 1'b1;
   typedef enum logic [1:0] {TPF_IDLE, TPF_EMIT} tpf_frame_state_t;
endpackage

// ### common/tpf_stream_if.sv
// Valid/ready byte stream between the framer, the FIFO and the transmitter.
`timescale 1ns/100ps
interface tpf_stream_if #(parameter int WIDTH = 8);
   logic [WIDTH-1:0] data;
   logic             valid;
   logic             ready;
   modport source (output data, output valid, input ready);
   modport sink   (input data, input valid, output ready);
endinterface

// ### design/tpf_fifo.sv
// Synchronous FIFO with valid/ready on both sides and registered read data.
`timescale 1ns/100ps
module tpf_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   input  wire logic   core_clk,
   input  wire logic   resetn,
   tpf_stream_if.sink   wr,
   tpf_stream_if.source rd
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW-1:0]    wptr_reg;
   logic [AW-1:0]    rptr_reg;
   logic [AW:0]      count_reg;
   logic [WIDTH-1:0] out_reg;
   logic             out_valid_reg;
   logic             push;
   logic             pop;
   logic             load;

   assign wr.ready = (count_reg != (AW+1)'(DEPTH));
   assign push     = wr.valid && wr.ready;
   assign load     = (count_reg != '0) && (!out_valid_reg || rd.ready);
   assign pop      = load;
   assign rd.valid = out_valid_reg;
   assign rd.data  = out_reg;

   always_ff @(posedge core_clk) begin
      if (push) begin
         mem_reg[wptr_reg] <= wr.data;
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         wptr_reg  <= '0;
         rptr_reg  <= '0;
         count_reg <= '0;
      end else begin
         if (push) begin
            wptr_reg <= wptr_reg + 1'b1;
         end
         if (pop) begin
            rptr_reg <= rptr_reg + 1'b1;
         end
         count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         out_reg       <= '0;
         out_valid_reg <= 1'b0;
      end else if (load) begin
         out_reg       <= mem_reg[rptr_reg];
         out_valid_reg <= 1'b1;
      end else if (rd.ready) begin
         out_valid_reg <= 1'b0;
      end
   end
endmodule

// ### design/tpf_uart_tx.sv
// 8-N-1 serial transmitter with a selectable bit period.
`timescale 1ns/100ps
module tpf_uart_tx
   import tpf_pkg::*;
(
   input  wire logic   core_clk,
   input  wire logic   resetn,
   input  wire logic   baud_high,
   tpf_stream_if.sink  in,
   output logic        txd
);
   logic [TPF_DIV_W-1:0] div_reg;
   logic [3:0]           bit_reg;
   logic [9:0]           shift_reg;
   logic                 busy_reg;

   assign in.ready = !busy_reg;
   // Ones refill the shift register, so its low bit also holds the idle level.
   assign txd      = shift_reg[0];

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         div_reg   <= '0;
         bit_reg   <= '0;
         shift_reg <= '1;
         busy_reg  <= 1'b0;
      end else if (!busy_reg) begin
         if (in.valid) begin
            // Stop bit, eight data bits LSB first, start bit.
            shift_reg <= {1'b1, in.data, 1'b0};
            busy_reg  <= 1'b1;
            bit_reg   <= '0;
            div_reg   <= baud_high ? TPF_DIV_W'(TPF_DIV_HIGH - 1) : TPF_DIV_W'(TPF_DIV_LOW - 1);
         end
      end else if (div_reg != '0) begin
         div_reg <= div_reg - 1'b1;
      end else begin
         shift_reg <= {1'b1, shift_reg[9:1]};
         div_reg   <= baud_high ? TPF_DIV_W'(TPF_DIV_HIGH - 1) : TPF_DIV_W'(TPF_DIV_LOW - 1);
         if (bit_reg == 4'(TPF_UART_BITS - 1)) begin
            busy_reg <= 1'b0;
         end else begin
            bit_reg <= bit_reg + 1'b1;
         end
      end
   end

   property p_frame_len;
      @(posedge core_clk) disable iff (!resetn)
      (in.valid && in.ready) |=> busy_reg [*8];
   endproperty
   AST_TX_FRAME_HELD: assert property (p_frame_len)
      else $error("Transmitter dropped a byte frame early.");
   AST_TX_START_BIT: assert property (@(posedge core_clk) disable iff (!resetn)
      (in.valid && in.ready) |=> !txd)
      else $error("Start bit was not low.");
   AST_TX_IDLE_HIGH: assert property (@(posedge core_clk) disable iff (!resetn)
      !busy_reg |-> txd)
      else $error("Idle line was not high.");
endmodule

// ### design/tpf_framer.sv
// Builds ten-byte measurement packets and sends them over the 8-N-1 serial line.
`timescale 1ns/100ps
module tpf_framer
   import tpf_pkg::*;
#(
   parameter int FIFO_DEPTH = TPF_FIFO_DEPTH
) (
   input  wire logic                   core_clk,
   input  wire logic                   resetn,
   input  wire logic                   mode_select_pin,
   input  wire logic                   baud_select_pin,
   input  wire logic                   sample_valid,
   input  wire logic [TPF_ANGLE_W-1:0] tilt_first_axis,
   input  wire logic [TPF_ANGLE_W-1:0] tilt_second_axis,
   input  wire logic [TPF_ANGLE_W-1:0] rotation_normal,
   input  wire logic [TPF_ANGLE_W-1:0] tilt_normal_axis,
   input  wire logic [TPF_ANGLE_W-1:0] reserved_word,
   input  wire logic                   send_once,
   input  wire logic                   stream_enable,
   output logic                        sample_ready,
   output logic                        packet_busy,
   output logic                        mode_two_axis,
   output logic                        txd
);
   tpf_stream_if #(.WIDTH(8)) frm_s ();
   tpf_stream_if #(.WIDTH(8)) tx_s ();

   logic                   mode_meta_reg;
   logic                   mode_sync_reg;
   logic                   baud_meta_reg;
   logic                   baud_sync_reg;
   tpf_frame_state_t       state_reg;
   logic [3:0]             pos_reg;
   logic [TPF_ANGLE_W-1:0] word_a_reg;
   logic [TPF_ANGLE_W-1:0] word_b_reg;
   logic [TPF_ANGLE_W-1:0] word_r_reg;
   logic [TPF_ANGLE_W-1:0] csum_reg;
   logic                   pending_reg;
   logic [7:0]             byte_out;
   logic                   start;
   logic                   last_byte;

   // Pins pass two flip-flops before use.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         mode_meta_reg <= TPF_MODE_TWO_AXIS;
         mode_sync_reg <= TPF_MODE_TWO_AXIS;
      end else begin
         mode_meta_reg <= mode_select_pin;
         mode_sync_reg <= mode_meta_reg;
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         baud_meta_reg <= 1'b1;
         baud_sync_reg <= 1'b1;
      end else begin
         baud_meta_reg <= baud_select_pin;
         baud_sync_reg <= baud_meta_reg;
      end
   end

   assign mode_two_axis = mode_sync_reg;

   // A single request is held until a sample is taken for it.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         pending_reg <= 1'b0;
      end else if (send_once) begin
         pending_reg <= 1'b1;
      end else if (start) begin
         pending_reg <= 1'b0;
      end
   end

   assign sample_ready = (state_reg == TPF_IDLE) && (pending_reg || stream_enable);
   assign start        = sample_ready && sample_valid;
   assign packet_busy  = (state_reg == TPF_EMIT);
   assign last_byte    = (pos_reg == TPF_POS_LAST) && frm_s.ready;

   // Angle words are captured whole, so a packet never mixes two samples.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         word_a_reg <= '0;
         word_b_reg <= '0;
         word_r_reg <= '0;
         csum_reg   <= '0;
      end else if (start) begin
         if (mode_sync_reg == TPF_MODE_TWO_AXIS) begin
            word_a_reg <= tilt_first_axis;
            word_b_reg <= tilt_second_axis;
            csum_reg   <= tilt_first_axis + tilt_second_axis + reserved_word;
         end else begin
            word_a_reg <= rotation_normal;
            word_b_reg <= tilt_normal_axis;
            csum_reg   <= rotation_normal + tilt_normal_axis + reserved_word;
         end
         word_r_reg <= reserved_word;
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         state_reg <= TPF_IDLE;
         pos_reg   <= TPF_POS_SYNC1;
      end else begin
         case (state_reg)
            TPF_IDLE: begin
               if (start) begin
                  state_reg <= TPF_EMIT;
                  pos_reg   <= TPF_POS_SYNC1;
               end
            end
            TPF_EMIT: begin
               if (frm_s.ready) begin
                  if (pos_reg == TPF_POS_LAST) begin
                     state_reg <= TPF_IDLE;
                  end else begin
                     pos_reg <= pos_reg + 1'b1;
                  end
               end
            end
            default: begin
               state_reg <= TPF_IDLE;
            end
         endcase
      end
   end

   always_comb begin
      case (pos_reg)
         TPF_POS_SYNC1:           byte_out = TPF_SYNC_BYTE;
         TPF_POS_SYNC2:           byte_out = TPF_SYNC_BYTE;
         TPF_POS_AXIS_A_HI:       byte_out = word_a_reg[15:8];
         TPF_POS_AXIS_A_HI + 4'h1: byte_out = word_a_reg[7:0];
         TPF_POS_AXIS_B_HI:       byte_out = word_b_reg[15:8];
         TPF_POS_AXIS_B_HI + 4'h1: byte_out = word_b_reg[7:0];
         TPF_POS_RSV_HI:          byte_out = word_r_reg[15:8];
         TPF_POS_RSV_HI + 4'h1:   byte_out = word_r_reg[7:0];
         TPF_POS_CSUM_HI:         byte_out = csum_reg[15:8];
         TPF_POS_LAST:            byte_out = csum_reg[7:0];
         default:                 byte_out = 8'h00;
      endcase
   end

   assign frm_s.data  = byte_out;
   assign frm_s.valid = packet_busy;

   tpf_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
      .core_clk (core_clk),
      .resetn   (resetn),
      .wr       (frm_s),
      .rd       (tx_s)
   );

   tpf_uart_tx u_tx (
      .core_clk  (core_clk),
      .resetn    (resetn),
      .baud_high (baud_sync_reg),
      .in        (tx_s),
      .txd       (txd)
   );

   // Helper counting bytes accepted in the current packet.
   logic [3:0] acc_cnt_reg;
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         acc_cnt_reg <= '0;
      end else if (frm_s.valid && frm_s.ready) begin
         acc_cnt_reg <= (acc_cnt_reg == TPF_POS_LAST) ? 4'h0 : acc_cnt_reg + 1'b1;
      end
   end

   sequence s_sync_pair;
      (frm_s.valid && pos_reg == TPF_POS_SYNC1) ##0 (frm_s.data == TPF_SYNC_BYTE);
   endsequence

   sequence s_ten_busy;
      packet_busy [*8] ##1 packet_busy [*2];
   endsequence

   sequence s_packet_end;
      (packet_busy && last_byte) ##1 !packet_busy;
   endsequence

   property p_stall_holds;
      @(posedge core_clk) disable iff (!resetn)
      (frm_s.valid && !frm_s.ready) |=> (packet_busy && $stable(pos_reg));
   endproperty

   AST_SYNC_FIRST: assert property (@(posedge core_clk) disable iff (!resetn)
      (frm_s.valid && pos_reg <= TPF_POS_SYNC2) |-> frm_s.data == TPF_SYNC_BYTE)
      else $error("Sync byte was not 0xFE.");
   AST_START_AT_SYNC: assert property (@(posedge core_clk) disable iff (!resetn)
      start |=> s_sync_pair)
      else $error("Packet did not open with sync.");
   AST_CSUM_VALUE: assert property (@(posedge core_clk) disable iff (!resetn)
      packet_busy |-> csum_reg == 16'(word_a_reg + word_b_reg + word_r_reg))
      else $error("Checksum does not match payload.");
   AST_HIGH_FIRST: assert property (@(posedge core_clk) disable iff (!resetn)
      (frm_s.valid && pos_reg == TPF_POS_AXIS_A_HI) |-> frm_s.data == word_a_reg[15:8])
      else $error("First field not sent high byte first.");
   AST_TEN_BYTES: assert property (@(posedge core_clk) disable iff (!resetn)
      (frm_s.valid && frm_s.ready && pos_reg == TPF_POS_LAST) |-> acc_cnt_reg == TPF_POS_LAST)
      else $error("Packet length is not ten bytes.");
   AST_MODE_FIELD: assert property (@(posedge core_clk) disable iff (!resetn)
      (start && mode_sync_reg) |=> word_a_reg == $past(tilt_first_axis))
      else $error("Two-axis mode did not pick the first-axis incline.");
   AST_ROT_FIELD: assert property (@(posedge core_clk) disable iff (!resetn)
      (start && !mode_sync_reg) |=> word_a_reg == $past(rotation_normal))
      else $error("Rotation mode did not pick the rotation angle.");
   AST_SECOND_FIELD: assert property (@(posedge core_clk) disable iff (!resetn)
      (start && mode_sync_reg) |=> word_b_reg == $past(tilt_second_axis))
      else $error("Two-axis mode did not pick the second-axis incline.");
   AST_MODE_SYNC: assert property (@(posedge core_clk) disable iff (!resetn)
      $changed(mode_select_pin) |-> ##2 (mode_two_axis == $past(mode_select_pin, 2)))
      else $error("Mode pin not reflected two cycles later.");

   // Every remaining byte slot carries its own half word.
   AST_SECOND_HIGH_FIRST: assert property (@(posedge core_clk) disable iff (!resetn)
      (frm_s.valid && pos_reg == TPF_POS_AXIS_B_HI) |-> frm_s.data == word_b_reg[15:8])
      else $error("Second field not sent high byte first.");
   AST_FIRST_LOW_BYTE: assert property (@(posedge core_clk) disable iff (!resetn)
      (frm_s.valid && pos_reg == TPF_POS_AXIS_A_HI + 4'h1) |-> frm_s.data == word_a_reg[7:0])
      else $error("First field low byte misplaced.");
   AST_SECOND_LOW_BYTE: assert property (@(posedge core_clk) disable iff (!resetn)
      (frm_s.valid && pos_reg == TPF_POS_AXIS_B_HI + 4'h1) |-> frm_s.data == word_b_reg[7:0])
      else $error("Second field low byte misplaced.");
   AST_RSV_HIGH_BYTE: assert property (@(posedge core_clk) disable iff (!resetn)
      (frm_s.valid && pos_reg == TPF_POS_RSV_HI) |-> frm_s.data == word_r_reg[15:8])
      else $error("Reserved high byte misplaced.");
   AST_RSV_LOW_BYTE: assert property (@(posedge core_clk) disable iff (!resetn)
      (frm_s.valid && pos_reg == TPF_POS_RSV_HI + 4'h1) |-> frm_s.data == word_r_reg[7:0])
      else $error("Reserved low byte misplaced.");
   AST_CSUM_HIGH_BYTE: assert property (@(posedge core_clk) disable iff (!resetn)
      (frm_s.valid && pos_reg == TPF_POS_CSUM_HI) |-> frm_s.data == csum_reg[15:8])
      else $error("Checksum high byte misplaced.");
   AST_CSUM_LOW_BYTE: assert property (@(posedge core_clk) disable iff (!resetn)
      (frm_s.valid && pos_reg == TPF_POS_LAST) |-> frm_s.data == csum_reg[7:0])
      else $error("Checksum low byte misplaced.");

   // Captured words come from the inputs of the taking edge and hold for the packet.
   AST_ROT_SECOND_FIELD: assert property (@(posedge core_clk) disable iff (!resetn)
      (start && !mode_sync_reg) |=> word_b_reg == $past(tilt_normal_axis))
      else $error("Rotation mode did not pick the normal-axis incline.");
   AST_RSV_CAPTURE: assert property (@(posedge core_clk) disable iff (!resetn)
      start |=> word_r_reg == $past(reserved_word))
      else $error("Reserved word not captured.");
   AST_WORDS_HELD: assert property (@(posedge core_clk) disable iff (!resetn)
      packet_busy |=> ($stable(word_a_reg) && $stable(word_b_reg) && $stable(word_r_reg) && $stable(csum_reg)))
      else $error("Packet words changed during a packet.");
   AST_TWO_AXIS_CSUM: assert property (@(posedge core_clk) disable iff (!resetn)
      (start && mode_sync_reg) |=> csum_reg ==
         16'($past(tilt_first_axis) + $past(tilt_second_axis) + $past(reserved_word)))
      else $error("Two-axis checksum does not match the inputs.");
   AST_ROT_CSUM: assert property (@(posedge core_clk) disable iff (!resetn)
      (start && !mode_sync_reg) |=> csum_reg ==
         16'($past(rotation_normal) + $past(tilt_normal_axis) + $past(reserved_word)))
      else $error("Rotation checksum does not match the inputs.");

   // Requests, refusal and packet length.
   AST_PENDING_SET: assert property (@(posedge core_clk) disable iff (!resetn)
      send_once |=> pending_reg)
      else $error("Single request was not held.");
   AST_PENDING_CLEAR: assert property (@(posedge core_clk) disable iff (!resetn)
      (start && !send_once) |=> !pending_reg)
      else $error("Single request was not cleared when taken.");
   AST_NO_REQUEST_IDLE: assert property (@(posedge core_clk) disable iff (!resetn)
      (!pending_reg && !stream_enable) |-> !sample_ready)
      else $error("Sample taken without a request.");
   AST_REFUSE_BUSY: assert property (@(posedge core_clk) disable iff (!resetn)
      packet_busy |-> !sample_ready)
      else $error("Sample offered while a packet is running.");
   AST_BUSY_TEN: assert property (@(posedge core_clk) disable iff (!resetn)
      start |=> s_ten_busy)
      else $error("Packet ended before ten bytes.");
   AST_PACKET_END: assert property (@(posedge core_clk) disable iff (!resetn)
      (packet_busy && last_byte) |-> s_packet_end)
      else $error("Packet did not end after its last byte.");
   AST_STREAM_RESTART: assert property (@(posedge core_clk) disable iff (!resetn)
      (s_packet_end ##0 (stream_enable && sample_valid)) |=> packet_busy)
      else $error("Stream did not start the next packet.");
   AST_POS_BOUND: assert property (@(posedge core_clk) disable iff (!resetn)
      packet_busy |-> pos_reg <= TPF_POS_LAST)
      else $error("Byte position beyond the packet.");
   AST_POS_STEP: assert property (@(posedge core_clk) disable iff (!resetn)
      (frm_s.valid && frm_s.ready && pos_reg != TPF_POS_LAST) |=> pos_reg == $past(pos_reg) + 4'h1)
      else $error("Byte position skipped or repeated.");
   AST_SECOND_SYNC: assert property (@(posedge core_clk) disable iff (!resetn)
      (frm_s.valid && frm_s.ready && pos_reg == TPF_POS_SYNC2) |=> pos_reg == TPF_POS_AXIS_A_HI)
      else $error("Payload did not follow the second sync byte.");
   AST_STALL_HOLD: assert property (p_stall_holds)
      else $error("Byte position moved while the buffer was full.");

   // The baud pin follows the same two-stage path as the mode pin.
   AST_BAUD_SYNC: assert property (@(posedge core_clk) disable iff (!resetn)
      $changed(baud_select_pin) |-> ##2 (baud_sync_reg == $past(baud_select_pin, 2)))
      else $error("Baud pin not reflected two cycles later.");
endmodule

// ### verification/tpf_host_rx.sv
// Host receiver model that decodes 8-N-1 bytes and checks measurement packets.
`timescale 1ns/100ps
module tpf_host_rx
   import tpf_pkg::*;
(
   input  wire logic   core_clk,
   input  wire logic   baud_high,
   input  wire logic   txd,
   output logic [79:0] last_pkt,
   output logic [15:0] good_cnt,
   output logic [15:0] bad_cnt,
   output logic [15:0] byte_cnt
);
   logic [7:0]  rx_byte;
   logic [79:0] shift;
   logic [15:0] sum;
   int          div;
   int          pos;

   initial begin
      last_pkt = 80'h0;
      good_cnt = 16'h0;
      bad_cnt = 16'h0;
      byte_cnt = 16'h0;
      shift = 80'h0;
      pos = 0;
      forever begin
         @(negedge txd);
         div = baud_high ? TPF_DIV_HIGH : TPF_DIV_LOW;
         repeat (div / 2) @(posedge core_clk);
         if (txd === 1'b0) begin
            for (int i = 0; i < 8; i++) begin
               repeat (div) @(posedge core_clk);
               rx_byte[i] = txd;
            end
            repeat (div) @(posedge core_clk);
            if (txd !== 1'b1) bad_cnt++;
            byte_cnt++;
            // Hunt for two sync bytes, then collect the rest of the packet.
            if (pos < 2 && rx_byte !== TPF_SYNC_BYTE) pos = 0;
            else begin
               shift = {shift[71:0], rx_byte};
               pos++;
            end
            if (pos == TPF_PKT_LEN) begin
               // The reserved field is summed but its value is not trusted.
               sum = shift[63:48] + shift[47:32] + shift[31:16];
               if (sum === shift[15:0]) begin
                  good_cnt++;
                  last_pkt = shift;
               end
               else bad_cnt++;
               pos = 0;
            end
         end
      end
   end
endmodule

// ### verification/testbench.sv
// Self-checking testbench of the tilt packet framer with a host receiver model.
`timescale 1ns/100ps
module testbench;
   import tpf_pkg::*;
   logic        core_clk;
   logic        resetn;
   logic        mode_select_pin;
   logic        baud_select_pin;
   logic        sample_valid;
   logic [15:0] tilt_first_axis;
   logic [15:0] tilt_second_axis;
   logic [15:0] rotation_normal;
   logic [15:0] tilt_normal_axis;
   logic [15:0] reserved_word;
   logic        send_once;
   logic        stream_enable;
   logic        sample_ready;
   logic        packet_busy;
   logic        mode_two_axis;
   logic        txd;
   logic [79:0] last_pkt;
   logic [15:0] good_cnt;
   logic [15:0] bad_cnt;
   logic [15:0] byte_cnt;
   int          failures;
   int          checked;

   tpf_framer i_tpf_framer (.core_clk(core_clk), .resetn(resetn), .mode_select_pin(mode_select_pin),
      .baud_select_pin(baud_select_pin), .sample_valid(sample_valid), .tilt_first_axis(tilt_first_axis),
      .tilt_second_axis(tilt_second_axis), .rotation_normal(rotation_normal),
      .tilt_normal_axis(tilt_normal_axis), .reserved_word(reserved_word), .send_once(send_once),
      .stream_enable(stream_enable), .sample_ready(sample_ready), .packet_busy(packet_busy),
      .mode_two_axis(mode_two_axis), .txd(txd));

   tpf_host_rx i_tpf_host_rx (.core_clk(core_clk), .baud_high(baud_select_pin), .txd(txd),
      .last_pkt(last_pkt), .good_cnt(good_cnt), .bad_cnt(bad_cnt), .byte_cnt(byte_cnt));

   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] expv);
      checked++;
      if (seen !== expv) begin
         failures++;
         $display("wrong value %s expected %h seen %h", name, expv, seen);
      end
   endtask

   task automatic report_and_stop();
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   task automatic wait_busy(input logic level);
      int t;
      t = 0;
      @(negedge core_clk);
      while (packet_busy !== level && t < 100) begin
         @(negedge core_clk);
         t++;
      end
      check("packet_busy", {15'h0, packet_busy}, {15'h0, level});
   endtask

   task automatic wait_host(input logic [15:0] n);
      int t;
      t = 0;
      while (good_cnt !== n && t < 80000) begin
         @(posedge core_clk);
         t++;
      end
      check("good packets", good_cnt, n);
      check("bad packets", bad_cnt, 16'h0000);
   endtask

   task automatic set_inputs(input logic mode, input logic baud, input logic [15:0] f, input logic [15:0] s,
                             input logic [15:0] rot, input logic [15:0] nrm, input logic [15:0] rsv);
      @(posedge core_clk);
      mode_select_pin <= mode;
      baud_select_pin <= baud;
      tilt_first_axis <= f;
      tilt_second_axis <= s;
      rotation_normal <= rot;
      tilt_normal_axis <= nrm;
      reserved_word <= rsv;
      repeat (4) @(posedge core_clk);
      check("mode_two_axis", {15'h0, mode_two_axis}, {15'h0, mode});
   endtask

   task automatic send_packet();
      @(negedge core_clk);
      check("sample_ready idle", {15'h0, sample_ready}, 16'h0000);
      @(posedge core_clk);
      send_once <= 1'b1;
      @(posedge core_clk);
      send_once <= 1'b0;
      @(negedge core_clk);
      check("sample_ready pending", {15'h0, sample_ready}, 16'h0001);
      @(posedge core_clk);
      sample_valid <= 1'b1;
      wait_busy(1'b1);
      @(posedge core_clk);
      sample_valid <= 1'b0;
   endtask

   task automatic judge(input logic [15:0] a, input logic [15:0] b, input logic [15:0] r);
      logic [15:0] sum;
      sum = a + b + r;
      check("sync bytes", last_pkt[79:64], {TPF_SYNC_BYTE, TPF_SYNC_BYTE});
      check("axis a field", last_pkt[63:48], a);
      check("axis b field", last_pkt[47:32], b);
      check("reserved field", last_pkt[31:16], r);
      check("checksum", last_pkt[15:0], sum);
   endtask

   task automatic test_two_axis();
      // Ninety degrees horizontal and one hundred eighty pointing up.
      set_inputs(1'b1, 1'b1, 16'h0384, 16'h0708, 16'h0A8C, 16'h0111, 16'h1234);
      send_packet();
      wait_host(16'h0001);
      judge(16'h0384, 16'h0708, 16'h1234);
      check("byte count", byte_cnt, 16'h000A);
   endtask

   task automatic test_rotation_low();
      // Rotation of 270 degrees with a checksum that wraps past 16 bits.
      set_inputs(1'b0, 1'b0, 16'h0384, 16'h0708, 16'h0A8C, 16'hFFFF, 16'hF000);
      send_packet();
      wait_host(16'h0002);
      judge(16'h0A8C, 16'hFFFF, 16'hF000);
      check("byte count", byte_cnt, 16'h0014);
   endtask

   task automatic test_stream();
      set_inputs(1'b1, 1'b1, 16'h0000, 16'h0708, 16'h0384, 16'h0222, 16'h00FF);
      @(posedge core_clk);
      sample_valid <= 1'b1;
      stream_enable <= 1'b1;
      wait_busy(1'b1);
      wait_busy(1'b0);
      wait_busy(1'b1);
      @(posedge core_clk);
      stream_enable <= 1'b0;
      sample_valid <= 1'b0;
      wait_host(16'h0004);
      judge(16'h0000, 16'h0708, 16'h00FF);
      check("byte count", byte_cnt, 16'h0028);
   endtask

   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end

   initial begin
      repeat (98000) @(posedge core_clk);
      failures++;
      report_and_stop();
   end

   initial begin
      failures = 0;
      checked = 0;
      resetn = 1'b0;
      mode_select_pin = 1'b1;
      baud_select_pin = 1'b1;
      sample_valid = 1'b0;
      tilt_first_axis = 16'h0000;
      tilt_second_axis = 16'h0000;
      rotation_normal = 16'h0000;
      tilt_normal_axis = 16'h0000;
      reserved_word = 16'h0000;
      send_once = 1'b0;
      stream_enable = 1'b0;
      repeat (10) @(posedge core_clk);
      resetn <= 1'b1;
      test_two_axis();
      test_rotation_low();
      test_stream();
      report_and_stop();
   end
endmodule
